/* common/amr_defs.vh */
`ifndef AMR_DEFS_VH
`define AMR_DEFS_VH

// ************************************************************
// Access spaces
// ************************************************************
`define AMR_SPACE_COIL      2'h0
`define AMR_SPACE_HOLD      2'h1
`define AMR_SPACE_INPUT     2'h2

// ************************************************************
// Holding register addresses (high word at the lower address)
// ************************************************************
`define AMR_HR_PRESS_HI     16'h1770
`define AMR_HR_PRESS_LO     16'h1771
`define AMR_HR_TEMP_HI      16'h1772
`define AMR_HR_TEMP_LO      16'h1773
`define AMR_HR_HUMID_HI     16'h1776
`define AMR_HR_HUMID_LO     16'h1777
`define AMR_HR_PASS_0       16'h1AF4
`define AMR_HR_PASS_1       16'h1AF5
`define AMR_HR_PASS_2       16'h1AF6

// ************************************************************
// Coil addresses
// ************************************************************
`define AMR_CL_PRESS_VALID  16'h1770
`define AMR_CL_TEMP_VALID   16'h1771
`define AMR_CL_HUMID_VALID  16'h1772
`define AMR_CL_MAINT        16'h1773
`define AMR_CL_CHECK_TRIG   16'h1774
`define AMR_CL_CHECK_INHIB  16'h1775

// ************************************************************
// Input register addresses
// ************************************************************
`define AMR_IR_STATUS0      16'h138A
`define AMR_IR_STRIDE       16'h0011
`define AMR_IR_FAIL_HI      16'h149E
`define AMR_IR_FAIL_LO      16'h149F
`define AMR_IR_MREQ_HI      16'h14A0
`define AMR_IR_MREQ_LO      16'h14A1

// ************************************************************
// Component status word fields
// ************************************************************
`define AMR_ST_FAILURE      0
`define AMR_ST_MAINT_REQ    1
`define AMR_ST_FUNC_CHECK   2
`define AMR_ST_OUT_OF_SPEC  3
`define AMR_ST_EXTENDED     4
`define AMR_ST_UNDER_RANGE  5
`define AMR_ST_OVER_RANGE   6
`define AMR_ST_MAINTENANCE  7
`define AMR_ST_CHECK_CYCLE  8

// ************************************************************
// Collective word widths and reset values
// ************************************************************
`define AMR_FAIL_USED       29
`define AMR_MREQ_USED       16
`define AMR_RESET_WORD      16'h0000

`endif

/* hdl/amr_register_map.v */
// Operation
// - Pressure float in two holding registers from 6000.
// - Temperature float in two holding registers from 6002.
// - Humidity float in two holding registers from 6006.
// - Password string in three holding registers from 6900.
// - Coils 6000-6002 latch validity of pressure, temperature, humidity.
// - Latching coil 6003 is the remote maintenance switch.
// - Writing one to coil 6004 starts a check cycle, momentary.
// - Coil 6005 holding one suppresses automatic check cycles.
// - Latching coils keep the last written value.
// - Momentary coil gives one event, then reads inactive.
// - Status bits 0-4: failure, maint request, check, out of spec, extended.
// - Status bits 5-7: under range, over range, in maintenance.
// - Status bit 8 is check cycle running; bits 9-15 reserved.
// - Failure bits 0-7: memory to filter unit comms.
// - Failure bits 8-15: mirror comms to measured value file.
// - Failure bits 16-23: configuration file to evaluation comms.
// - Failure bits 24-28 as listed; bits 29-31 reserved.
// - Maintenance request bits 0-7: lamp performance to logbook.
// - Maintenance request bits 8-15: I/O comms to peak width.
// - Component status at input register 5002, stride 17.
// - Failure word in input registers 5278-5279.
// - Maintenance request word in input registers 5280-5281.
`timescale 1ns/1ps
`default_nettype none
`include "amr_defs.vh"

module amr_register_map #(
    parameter NCOMP = 16
) (
    input  wire               clk,
    input  wire               rst_n,
    input  wire               req_valid,
    input  wire               req_write,
    input  wire [1:0]         req_space,
    input  wire [15:0]        req_addr,
    input  wire [15:0]        req_wdata,
    output reg                rsp_valid,
    output reg                rsp_error,
    output reg  [15:0]        rsp_rdata,
    input  wire [28:0]        fail_in,
    input  wire [15:0]        maint_req_in,
    input  wire [NCOMP*5-1:0] comp_cond_in,
    input  wire               auto_check_req,
    input  wire               check_done,
    output reg  [31:0]        pressure_value,
    output reg  [31:0]        temperature_value,
    output reg  [31:0]        humidity_value,
    output reg  [47:0]        password_value,
    output reg                pressure_valid,
    output reg                temperature_valid,
    output reg                humidity_valid,
    output reg                maintenance_mode,
    output reg                check_inhibit,
    output reg                check_start,
    output reg                check_running
);

    // ************************************************************
    // Check cycle sequencer states
    // ************************************************************
    localparam [1:0] CK_IDLE = 2'b01;
    localparam [1:0] CK_RUN  = 2'b10;

    reg  [1:0]  ck_state_reg;
    reg  [1:0]  ck_state_next;
    reg         start_next;
    reg  [15:0] rdata_next;
    reg         error_next;
    reg  [15:0] status_word;
    reg  [15:0] scan_addr;
    reg  [16:0] scan_sum;
    reg         status_hit;
    reg  [4:0]  cond;
    integer     k;

    wire        wr = req_valid & req_write;
    wire        wr_hold = wr & (req_space == `AMR_SPACE_HOLD);
    wire        wr_coil = wr & (req_space == `AMR_SPACE_COIL);
    wire        trig_wr = wr_coil & (req_addr == `AMR_CL_CHECK_TRIG) & req_wdata[0];
    wire [31:0] fail_word = {3'h0, fail_in};
    wire [31:0] mreq_word = {16'h0000, maint_req_in};

    // ************************************************************
    // Holding registers and latching coils
    // ************************************************************
    // Each half of a float is written separately, so the consumer may see a
    // torn value between the two writes; the valid coils let the master fence it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pressure_value    <= 32'h00000000;
            temperature_value <= 32'h00000000;
            humidity_value    <= 32'h00000000;
            password_value    <= 48'h000000000000;
            pressure_valid    <= 1'b0;
            temperature_valid <= 1'b0;
            humidity_valid    <= 1'b0;
            maintenance_mode  <= 1'b0;
            check_inhibit     <= 1'b0;
        end else begin
            if (wr_hold) begin
                case (req_addr)
                    `AMR_HR_PRESS_HI: pressure_value[31:16]    <= req_wdata;
                    `AMR_HR_PRESS_LO: pressure_value[15:0]     <= req_wdata;
                    `AMR_HR_TEMP_HI:  temperature_value[31:16] <= req_wdata;
                    `AMR_HR_TEMP_LO:  temperature_value[15:0]  <= req_wdata;
                    `AMR_HR_HUMID_HI: humidity_value[31:16]    <= req_wdata;
                    `AMR_HR_HUMID_LO: humidity_value[15:0]     <= req_wdata;
                    `AMR_HR_PASS_0:   password_value[47:32]    <= req_wdata;
                    `AMR_HR_PASS_1:   password_value[31:16]    <= req_wdata;
                    `AMR_HR_PASS_2:   password_value[15:0]     <= req_wdata;
                    default: begin
                    end
                endcase
            end
            if (wr_coil) begin
                case (req_addr)
                    `AMR_CL_PRESS_VALID: pressure_valid    <= req_wdata[0];
                    `AMR_CL_TEMP_VALID:  temperature_valid <= req_wdata[0];
                    `AMR_CL_HUMID_VALID: humidity_valid    <= req_wdata[0];
                    `AMR_CL_MAINT:       maintenance_mode  <= req_wdata[0];
                    `AMR_CL_CHECK_INHIB: check_inhibit     <= req_wdata[0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Check cycle sequencer
    // ************************************************************
    // A trigger that lands while a cycle runs is dropped rather than queued,
    // so one push gives at most one cycle.
    always @* begin
        ck_state_next = ck_state_reg;
        start_next    = 1'b0;
        case (ck_state_reg)
            CK_IDLE: begin
                if (trig_wr || (auto_check_req && !check_inhibit)) begin
                    ck_state_next = CK_RUN;
                    start_next    = 1'b1;
                end
            end
            CK_RUN: begin
                if (check_done) begin
                    ck_state_next = CK_IDLE;
                end
            end
            default: begin
                ck_state_next = CK_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_state_reg  <= CK_IDLE;
            check_start   <= 1'b0;
            check_running <= 1'b0;
        end else begin
            ck_state_reg  <= ck_state_next;
            check_start   <= start_next;
            check_running <= (ck_state_next == CK_RUN);
        end
    end

    // ************************************************************
    // Read decode
    // ************************************************************
    always @* begin
        rdata_next  = `AMR_RESET_WORD;
        error_next  = 1'b0;
        status_word = `AMR_RESET_WORD;
        status_hit  = 1'b0;
        cond        = 5'h00;
        scan_addr   = `AMR_IR_STATUS0;
        scan_sum    = 17'h0;
        for (k = 0; k < NCOMP; k = k + 1) begin
            if (req_addr == scan_addr) begin
                status_hit = 1'b1;
                cond       = comp_cond_in[k*5 +: 5];
            end
            // The carry can never be set for legal component counts, so it is cut here.
            scan_sum  = {1'b0, scan_addr} + {1'b0, `AMR_IR_STRIDE};
            scan_addr = scan_sum[15:0];
        end
        status_word[`AMR_ST_FAILURE]     = |fail_word;
        status_word[`AMR_ST_MAINT_REQ]   = |mreq_word;
        status_word[`AMR_ST_FUNC_CHECK]  = cond[0];
        status_word[`AMR_ST_OUT_OF_SPEC] = cond[1];
        status_word[`AMR_ST_EXTENDED]    = cond[2];
        status_word[`AMR_ST_UNDER_RANGE] = cond[3];
        status_word[`AMR_ST_OVER_RANGE]  = cond[4];
        status_word[`AMR_ST_MAINTENANCE] = maintenance_mode;
        status_word[`AMR_ST_CHECK_CYCLE] = check_running;
        case (req_space)
            `AMR_SPACE_HOLD: begin
                case (req_addr)
                    `AMR_HR_PRESS_HI: rdata_next = pressure_value[31:16];
                    `AMR_HR_PRESS_LO: rdata_next = pressure_value[15:0];
                    `AMR_HR_TEMP_HI:  rdata_next = temperature_value[31:16];
                    `AMR_HR_TEMP_LO:  rdata_next = temperature_value[15:0];
                    `AMR_HR_HUMID_HI: rdata_next = humidity_value[31:16];
                    `AMR_HR_HUMID_LO: rdata_next = humidity_value[15:0];
                    `AMR_HR_PASS_0:   rdata_next = password_value[47:32];
                    `AMR_HR_PASS_1:   rdata_next = password_value[31:16];
                    `AMR_HR_PASS_2:   rdata_next = password_value[15:0];
                    default:          error_next = 1'b1;
                endcase
            end
            `AMR_SPACE_COIL: begin
                case (req_addr)
                    `AMR_CL_PRESS_VALID: rdata_next = {15'h0000, pressure_valid};
                    `AMR_CL_TEMP_VALID:  rdata_next = {15'h0000, temperature_valid};
                    `AMR_CL_HUMID_VALID: rdata_next = {15'h0000, humidity_valid};
                    `AMR_CL_MAINT:       rdata_next = {15'h0000, maintenance_mode};
                    `AMR_CL_CHECK_TRIG:  rdata_next = `AMR_RESET_WORD;
                    `AMR_CL_CHECK_INHIB: rdata_next = {15'h0000, check_inhibit};
                    default:             error_next = 1'b1;
                endcase
            end
            `AMR_SPACE_INPUT: begin
                if (req_write) begin
                    error_next = 1'b1;
                end else if (status_hit) begin
                    rdata_next = status_word;
                end else begin
                    case (req_addr)
                        `AMR_IR_FAIL_HI: rdata_next = fail_word[31:16];
                        `AMR_IR_FAIL_LO: rdata_next = fail_word[15:0];
                        `AMR_IR_MREQ_HI: rdata_next = mreq_word[31:16];
                        `AMR_IR_MREQ_LO: rdata_next = mreq_word[15:0];
                        default:         error_next = 1'b1;
                    endcase
                end
            end
            default: begin
                error_next = 1'b1;
            end
        endcase
        if (req_write && !error_next) begin
            rdata_next = `AMR_RESET_WORD;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= `AMR_RESET_WORD;
        end else begin
            rsp_valid <= req_valid;
            rsp_error <= req_valid & error_next;
            rsp_rdata <= req_valid ? (error_next ? `AMR_RESET_WORD : rdata_next)
                                   : `AMR_RESET_WORD;
        end
    end

endmodule // amr_register_map
`default_nettype wire

/* verification/amr_map_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "amr_defs.vh"
module amr_map_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [1:0]  req_space,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic        rsp_error,
    input wire logic        auto_check_req,
    input wire logic        check_done,
    input wire logic [31:0] pressure_value,
    input wire logic        maintenance_mode,
    input wire logic        check_inhibit,
    input wire logic        check_start,
    input wire logic        check_running
);
    wire cw = req_valid && req_write && req_space == `AMR_SPACE_COIL;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RSP_TIMING: assert property (rsp_valid == $past(req_valid))
        else $error("response not one cycle after request");
    AST_INPUT_RO: assert property (req_valid && req_write
        && req_space == `AMR_SPACE_INPUT |=> rsp_error)
        else $error("input register write not refused");
    AST_PRESS_HI: assert property (req_valid && req_write && req_space == `AMR_SPACE_HOLD
        && req_addr == `AMR_HR_PRESS_HI |=> pressure_value[31:16] == $past(req_wdata))
        else $error("pressure high word not written");
    AST_MAINT_SW: assert property (cw && req_addr == `AMR_CL_MAINT
        |=> maintenance_mode == $past(req_wdata[0])) else $error("maintenance coil wrong");
    AST_LATCH_HOLD: assert property (!cw
        |=> $stable(maintenance_mode) && $stable(check_inhibit))
        else $error("latching coil changed without write");
    AST_TRIG_START: assert property (cw && req_addr == `AMR_CL_CHECK_TRIG && req_wdata[0]
        && !check_running |=> check_start && check_running) else $error("trigger did not start");
    AST_TRIG_PULSE: assert property (check_start |=> !check_start)
        else $error("start longer than one cycle");
    AST_INHIBIT: assert property (check_inhibit && !check_running && !cw |=> !check_start)
        else $error("cycle started while inhibited");
    AST_RUN_END: assert property (check_running && check_done && !auto_check_req && !cw
        |=> !check_running) else $error("check cycle did not end");
    AST_RUN_HOLD: assert property (check_running && !check_done |=> check_running)
        else $error("check cycle dropped early");
endmodule // amr_map_sva
bind amr_register_map amr_map_sva u_sva (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .auto_check_req(auto_check_req),
    .check_done(check_done), .pressure_value(pressure_value),
    .maintenance_mode(maintenance_mode), .check_inhibit(check_inhibit),
    .check_start(check_start), .check_running(check_running));
`default_nettype wire

/* verification/amr_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module amr_master_model (
    input  wire logic        clk,
    output var  logic        req_valid,
    output var  logic        req_write,
    output var  logic [1:0]  req_space,
    output var  logic [15:0] req_addr,
    output var  logic [15:0] req_wdata,
    input  wire logic        rsp_error,
    input  wire logic [15:0] rsp_rdata
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_space = 2'h0;
        req_addr  = 16'h0000;
        req_wdata = 16'h0000;
    end
    // Address and write data are inverted after release so a stale value can never pass as valid.
    task automatic xfer(input logic w, input logic [1:0] sp, input logic [15:0] a, d,
                        output logic [15:0] q, output logic e);
        @(negedge clk);
        req_valid = 1'b1;
        req_write = w;
        req_space = sp;
        req_addr  = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
        req_addr  = ~a;
        req_wdata = ~d;
        q = rsp_rdata;
        e = rsp_error;
    endtask
endmodule // amr_master_model
`default_nettype wire

/* verification/amr_register_map_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "amr_defs.vh"
module amr_register_map_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid, req_write, rsp_valid, rsp_error, e;
    logic [1:0]  req_space;
    logic [15:0] req_addr, req_wdata, rsp_rdata, q;
    logic [28:0] fail_in = 29'h0;
    logic [15:0] maint_req_in = 16'h0000;
    logic [79:0] comp_cond_in = 80'h0;
    logic        auto_check_req = 1'b0;
    logic        check_done = 1'b0;
    logic [31:0] pv, tv, hv;
    logic [47:0] pw;
    logic        p_ok, t_ok, h_ok, mm, inh, cs, cr;
    int          bad_count = 0, n_checks = 0, n_start = 0, cyc = 0;
    logic [15:0] ha [9] = '{16'h1770, 16'h1771, 16'h1772, 16'h1773, 16'h1776, 16'h1777,
                            16'h1AF4, 16'h1AF5, 16'h1AF6};
    logic [15:0] ca [5] = '{16'h1770, 16'h1771, 16'h1772, 16'h1773, 16'h1775};
    amr_register_map #(.NCOMP(16)) DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_space(req_space), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .rsp_rdata(rsp_rdata), .fail_in(fail_in), .maint_req_in(maint_req_in),
        .comp_cond_in(comp_cond_in), .auto_check_req(auto_check_req),
        .check_done(check_done), .pressure_value(pv), .temperature_value(tv),
        .humidity_value(hv), .password_value(pw), .pressure_valid(p_ok),
        .temperature_valid(t_ok), .humidity_valid(h_ok), .maintenance_mode(mm),
        .check_inhibit(inh), .check_start(cs), .check_running(cr));
    amr_master_model m (.clk(clk), .req_valid(req_valid), .req_write(req_write),
        .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cs === 1'b1) n_start++;
        if (cyc == 5000) begin
            bad_count++;
            complete_run;
        end
    end
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] sp, input logic [15:0] a, d);
        m.xfer(w, sp, a, d, q, e);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_hold;
        for (int i = 0; i < 9; i++) acc(1'b1, `AMR_SPACE_HOLD, ha[i], 16'(16'h1111 * (i + 1)));
        check(pv, 32'h1111_2222);
        check(tv, 32'h3333_4444);
        check(hv, 32'h5555_6666);
        check(pw, 48'h7777_8888_9999);
        for (int i = 0; i < 9; i++) begin
            acc(1'b0, `AMR_SPACE_HOLD, ha[i], 16'h0000);
            check(q, 16'(16'h1111 * (i + 1)));
        end
        $display("holding test done");
    endtask
    task automatic t_coils;
        for (int i = 0; i < 5; i++) acc(1'b1, `AMR_SPACE_COIL, ca[i], 16'h0001);
        check({p_ok, t_ok, h_ok, mm, inh}, 5'h1F);
        acc(1'b1, `AMR_SPACE_COIL, 16'h1770, 16'h0000);
        acc(1'b1, `AMR_SPACE_COIL, 16'h1773, 16'h0000);
        repeat (3) @(negedge clk);
        check({p_ok, t_ok, h_ok, mm, inh}, 5'h0D);
        acc(1'b0, `AMR_SPACE_COIL, 16'h1771, 16'h0000);
        check(q, 16'h0001);
        $display("coil test done");
    endtask
    task automatic t_inhibit;
        auto_check_req = 1'b1;
        repeat (4) @(negedge clk);
        check(cr, 1'b0);
        acc(1'b1, `AMR_SPACE_COIL, 16'h1775, 16'h0000);
        @(negedge clk);
        check(cr, 1'b1);
        auto_check_req = 1'b0;
        check_done = 1'b1;
        @(negedge clk);
        check_done = 1'b0;
        check(cr, 1'b0);
        $display("inhibit test done");
    endtask
    task automatic t_trigger_status;
        n_start = 0;
        acc(1'b1, `AMR_SPACE_COIL, 16'h1774, 16'h0001);
        check(cr, 1'b1);
        acc(1'b0, `AMR_SPACE_COIL, 16'h1774, 16'h0000);
        check(q, 16'h0000);
        acc(1'b1, `AMR_SPACE_COIL, 16'h1774, 16'h0001);
        check(48'(n_start), 48'h1);
        fail_in = 29'h1081_8001;
        maint_req_in = 16'h8101;
        comp_cond_in[4:0] = 5'h15;
        comp_cond_in[79:75] = 5'h0A;
        acc(1'b1, `AMR_SPACE_COIL, 16'h1773, 16'h0001);
        acc(1'b0, `AMR_SPACE_INPUT, 16'h138A, 16'h0000);
        check(q, {7'h00, 1'b1, 1'b1, 5'h15, 1'b1, 1'b1});
        acc(1'b0, `AMR_SPACE_INPUT, 16'h1489, 16'h0000);
        check(q, {7'h00, 1'b1, 1'b1, 5'h0A, 1'b1, 1'b1});
        acc(1'b0, `AMR_SPACE_INPUT, 16'h149E, 16'h0000);
        check(q, 16'h1081);
        acc(1'b0, `AMR_SPACE_INPUT, 16'h149F, 16'h0000);
        check(q, 16'h8001);
        acc(1'b0, `AMR_SPACE_INPUT, 16'h14A0, 16'h0000);
        check(q, 16'h0000);
        acc(1'b0, `AMR_SPACE_INPUT, 16'h14A1, 16'h0000);
        check(q, 16'h8101);
        fail_in = 29'h0;
        maint_req_in = 16'h0000;
        check_done = 1'b1;
        @(negedge clk);
        check_done = 1'b0;
        acc(1'b1, `AMR_SPACE_COIL, 16'h1774, 16'h0000);
        acc(1'b0, `AMR_SPACE_INPUT, 16'h138A, 16'h0000);
        check(q, {7'h00, 1'b0, 1'b1, 5'h15, 1'b0, 1'b0});
        check(48'(n_start), 48'h1);
        $display("trigger and status test done");
    endtask
    task automatic t_errors;
        acc(1'b1, `AMR_SPACE_INPUT, 16'h138A, 16'h1234);
        check({e, q}, 17'h10000);
        acc(1'b0, `AMR_SPACE_INPUT, 16'h138B, 16'h0000);
        check({e, q}, 17'h10000);
        acc(1'b1, 2'h3, 16'h1770, 16'h1234);
        check({e, q}, 17'h10000);
        acc(1'b1, `AMR_SPACE_COIL, 16'h1776, 16'h0001);
        check({e, q}, 17'h10000);
        check({p_ok, t_ok, h_ok, mm, inh}, 5'h0E);
        acc(1'b1, `AMR_SPACE_HOLD, 16'h1774, 16'h1234);
        check({e, q}, 17'h10000);
        check(pv, 32'h1111_2222);
        acc(1'b1, `AMR_SPACE_HOLD, 16'h1771, 16'hABCD);
        check({e, q}, 17'h00000);
        check(pv, 32'h1111_ABCD);
        $display("error test done");
    endtask
    task automatic t_reset;
        rst_n = 1'b0;
        @(negedge clk);
        check({pv, mm, inh, cr, cs}, 36'h0);
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        acc(1'b0, `AMR_SPACE_COIL, 16'h1771, 16'h0000);
        check({e, q}, 17'h00000);
        $display("reset test done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        check({pv, p_ok, mm, cr}, 35'h0);
        t_hold;
        t_coils;
        t_inhibit;
        t_trigger_status;
        t_errors;
        t_reset;
        complete_run;
    end
endmodule // amr_register_map_tb
`default_nettype wire
